// *** src/sct_timing.sv ***
// scan, conversion and update timing engine
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R01 - pin edge of chosen polarity starts one scan
// R02 - internal conversions: scan start starts sample counter
// R03 - scan monitor shows real start; option one 50-100 ns high
// R04 - option two high during scan, drops delay after last conversion
// R05 - monitors tri-stated from reset until enabled
// R06 - conversions blocked until scan start
// R07 - external scan starts spaced a scan period apart
// R08 - scan counter makes starts; trigger starts, software or count stops
// R09 - scans and conversions only inside acquisition, gateable
// R10 - pin edge of chosen polarity starts one conversion
// R11 - conversion monitor: real strobe, 50-100 ns low
// R12 - converter holds within 60 ns of strobe edge
// R13 - sample counter reloads until scan ends, then waits
// R14 - mask level blocks; in edge mode edges toggle blocking
// R15 - mask acts only at scan boundaries
// R16 - scan counter clock: external level pin or timebase; code counts edges of chosen polarity on the routed pin
// R17 - waveform trigger edge starts generation and update counter
// R18 - trigger monitor: real trigger, 50-100 ns high
// R19 - update edge loads dacs only in posted mode
// R20 - update monitor: real update, 300-350 ns low
// R21 - external updates: one more pulse than points
// R22 - update counter: trigger starts, software or count stops, gate suppresses
// R23 - acquisition trigger edge begins acquisition
// R24 - pins synchronised, then polarity, then detection
module sct_timing #(
    parameter int unsigned CW = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sct_pkg::sct_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [sct_pkg::NUM_PINS-1:0] pin_i,
    input wire logic tb_fast_tick_i,
    input wire logic tb_slow_tick_i,
    output logic adc_convert_o,
    output logic dac_update_o,
    output sct_pkg::sct_mon_t mon_o,
    output logic [3:0] mon_oe_n_o,
    output logic wf_done_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl_q, route_q, pol_q;
    logic [3:0] mon_en_q;
    logic [CW-1:0] si_load_q, smp_load_q, up_load_q, conv_n_q, scan_n_q, point_n_q;
    logic [31:0] wmask;
    logic wr_en, rd_en;
    logic [3:0] cmd;
    logic [31:0] status;
    logic [31:0] rdata;

    assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    assign wr_en = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o;
    assign rd_en = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !wb_ack_o;
    assign cmd = (wr_en && wb_req_i.adr == sct_pkg::OFF_CMD && wb_req_i.sel[0]) ? wb_req_i.dat[3:0] : 4'h0;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m, input logic [31:0] d);
        merge = (old & ~m) | (d & m);
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= sct_pkg::RST_ZERO;
            route_q <= sct_pkg::RST_ZERO;
            pol_q <= sct_pkg::RST_ZERO;
            mon_en_q <= 4'h0;
            si_load_q <= '0;
            smp_load_q <= '0;
            up_load_q <= '0;
            conv_n_q <= '0;
            scan_n_q <= '0;
            point_n_q <= '0;
        end else if (wr_en) begin
            if (wb_req_i.adr == sct_pkg::OFF_CTRL) begin
                ctrl_q <= merge(ctrl_q, wmask, wb_req_i.dat);
            end else if (wb_req_i.adr == sct_pkg::OFF_ROUTE) begin
                route_q <= merge(route_q, wmask, wb_req_i.dat);
            end else if (wb_req_i.adr == sct_pkg::OFF_POL) begin
                pol_q <= merge(pol_q, wmask, wb_req_i.dat);
            end else if (wb_req_i.adr == sct_pkg::OFF_MON_EN && wb_req_i.sel[0]) begin
                mon_en_q <= wb_req_i.dat[3:0];
            end else if (wb_req_i.adr == sct_pkg::OFF_SI_LOAD) begin
                si_load_q <= CW'(merge(32'(si_load_q), wmask, wb_req_i.dat));
            end else if (wb_req_i.adr == sct_pkg::OFF_SMP_LOAD) begin
                smp_load_q <= CW'(merge(32'(smp_load_q), wmask, wb_req_i.dat));
            end else if (wb_req_i.adr == sct_pkg::OFF_UP_LOAD) begin
                up_load_q <= CW'(merge(32'(up_load_q), wmask, wb_req_i.dat));
            end else if (wb_req_i.adr == sct_pkg::OFF_CONV_N) begin
                conv_n_q <= CW'(merge(32'(conv_n_q), wmask, wb_req_i.dat));
            end else if (wb_req_i.adr == sct_pkg::OFF_SCAN_N) begin
                scan_n_q <= CW'(merge(32'(scan_n_q), wmask, wb_req_i.dat));
            end else if (wb_req_i.adr == sct_pkg::OFF_POINT_N) begin
                point_n_q <= CW'(merge(32'(point_n_q), wmask, wb_req_i.dat));
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (wb_req_i.adr == sct_pkg::OFF_CTRL) begin
            rdata = ctrl_q;
        end else if (wb_req_i.adr == sct_pkg::OFF_ROUTE) begin
            rdata = route_q;
        end else if (wb_req_i.adr == sct_pkg::OFF_POL) begin
            rdata = pol_q;
        end else if (wb_req_i.adr == sct_pkg::OFF_MON_EN) begin
            rdata = {28'h0000000, mon_en_q};
        end else if (wb_req_i.adr == sct_pkg::OFF_SI_LOAD) begin
            rdata = 32'(si_load_q);
        end else if (wb_req_i.adr == sct_pkg::OFF_SMP_LOAD) begin
            rdata = 32'(smp_load_q);
        end else if (wb_req_i.adr == sct_pkg::OFF_UP_LOAD) begin
            rdata = 32'(up_load_q);
        end else if (wb_req_i.adr == sct_pkg::OFF_CONV_N) begin
            rdata = 32'(conv_n_q);
        end else if (wb_req_i.adr == sct_pkg::OFF_SCAN_N) begin
            rdata = 32'(scan_n_q);
        end else if (wb_req_i.adr == sct_pkg::OFF_POINT_N) begin
            rdata = 32'(point_n_q);
        end else if (wb_req_i.adr == sct_pkg::OFF_STATUS) begin
            rdata = status;
        end
    end

    // unmapped addresses still ack, reading zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
            wb_dat_o <= rd_en ? rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin routing: sync, polarity, then edge/level per function
    logic [sct_pkg::NUM_PINS-1:0] pin_s1_q, pin_s2_q;
    logic [sct_pkg::NUM_FN-1:0] lvl_q, lvl_prev_q, edge_hit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_i; // R24
            pin_s2_q <= pin_s1_q; // R24
        end
    end

    for (genvar f = 0; f < sct_pkg::NUM_FN; f++) begin : g_fn
        logic [sct_pkg::ROUTE_W-1:0] sel;
        logic raw;
        assign sel = route_q[f*sct_pkg::ROUTE_W +: sct_pkg::ROUTE_W];
        assign raw = (32'(sel) < sct_pkg::NUM_PINS) ? pin_s2_q[sel] : 1'b0;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                lvl_q[f] <= 1'b0;
                lvl_prev_q[f] <= 1'b0;
            end else begin
                lvl_q[f] <= raw ^ pol_q[f]; // R24
                lvl_prev_q[f] <= lvl_q[f];
            end
        end
        assign edge_hit[f] = lvl_q[f] && !lvl_prev_q[f]; // R01 R10 R17 R19
    end

    ////////////////////////////////////////////////////////////////////////////////
    // acquisition sequence and scan interval counter
    logic acq_q, scan_q, mask_tog_q, masked;
    logic [CW-1:0] si_cnt_q, smp_cnt_q, conv_left_q, scan_left_q;
    logic si_tick, si_fire, scan_req, scan_start, conv_req, conv_go, last_conv, acq_start;

    assign acq_start = ctrl_q[sct_pkg::CTRL_ACQ_EXT] ? edge_hit[sct_pkg::FN_ACQ] : cmd[sct_pkg::CMD_ACQ_TRIG]; // R23
    assign si_tick = ctrl_q[sct_pkg::CTRL_SI_EXT] ? edge_hit[sct_pkg::FN_SICLK] :
        (ctrl_q[sct_pkg::CTRL_TB_SLOW] ? tb_slow_tick_i : tb_fast_tick_i); // R16
    assign si_fire = acq_q && si_tick && si_cnt_q == '0;
    assign scan_req = ctrl_q[sct_pkg::CTRL_SCAN_EXT] ? edge_hit[sct_pkg::FN_SCAN] : si_fire; // R01 R08
    // mask sampled only at a scan start
    assign masked = (ctrl_q[sct_pkg::CTRL_MASK_EDGE] ? mask_tog_q : lvl_q[sct_pkg::FN_MASK])
        || ctrl_q[sct_pkg::CTRL_AI_GATE]; // R14
    assign scan_start = scan_req && acq_q && !scan_q && !masked; // R09 R15
    assign conv_req = ctrl_q[sct_pkg::CTRL_CONV_EXT] ? edge_hit[sct_pkg::FN_CONV] : smp_cnt_q == '0;
    assign conv_go = scan_q && conv_req; // R06 R09
    assign last_conv = conv_go && conv_left_q <= CW'(1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_tog_q <= 1'b0;
        end else if (!ctrl_q[sct_pkg::CTRL_MASK_EDGE]) begin
            mask_tog_q <= 1'b0; // R14
        end else if (edge_hit[sct_pkg::FN_MASK]) begin
            mask_tog_q <= !mask_tog_q; // R14
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acq_q <= 1'b0;
            si_cnt_q <= '0;
            scan_left_q <= '0;
        end else if (cmd[sct_pkg::CMD_ACQ_STOP]) begin
            acq_q <= 1'b0; // R08
        end else if (acq_start && !acq_q) begin
            acq_q <= 1'b1; // R08 R23
            si_cnt_q <= si_load_q;
            scan_left_q <= scan_n_q;
        end else if (acq_q) begin
            if (si_tick) begin
                si_cnt_q <= (si_cnt_q == '0) ? si_load_q : si_cnt_q - CW'(1); // R08
            end
            if (last_conv) begin
                scan_left_q <= scan_left_q - CW'(1);
                if (scan_left_q <= CW'(1)) begin
                    acq_q <= 1'b0; // R08
                end
            end
        end
    end

    // scan in progress and sample interval counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_q <= 1'b0;
            conv_left_q <= '0;
            smp_cnt_q <= '0;
        end else if (scan_start) begin
            scan_q <= 1'b1; // R01
            conv_left_q <= conv_n_q;
            smp_cnt_q <= smp_load_q; // R02
        end else if (scan_q) begin
            if (last_conv || !acq_q) begin
                scan_q <= 1'b0;
                smp_cnt_q <= smp_load_q; // R13
            end else if (!ctrl_q[sct_pkg::CTRL_CONV_EXT]) begin
                smp_cnt_q <= (smp_cnt_q == '0) ? smp_load_q : smp_cnt_q - CW'(1); // R13
            end
            if (conv_go) begin
                conv_left_q <= conv_left_q - CW'(1);
            end
        end else begin
            smp_cnt_q <= smp_load_q; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // waveform generation and update interval counter
    logic wf_q;
    logic [CW-1:0] up_cnt_q, pt_left_q;
    logic wf_start, up_tick, upd_req, upd_go;

    assign wf_start = !wf_q && (ctrl_q[sct_pkg::CTRL_WFT_EXT] ? edge_hit[sct_pkg::FN_WFT] : cmd[sct_pkg::CMD_WF_TRIG]);
    assign up_tick = ctrl_q[sct_pkg::CTRL_TB_SLOW] ? tb_slow_tick_i : tb_fast_tick_i;
    assign upd_req = ctrl_q[sct_pkg::CTRL_UPD_EXT] ? edge_hit[sct_pkg::FN_UPD] : (up_tick && up_cnt_q == '0); // R22
    // sw gate or non-posted mode swallows it
    assign upd_go = wf_q && upd_req && !ctrl_q[sct_pkg::CTRL_AO_GATE] && ctrl_q[sct_pkg::CTRL_DAC_POSTED]; // R19 R22

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wf_q <= 1'b0;
            up_cnt_q <= '0;
            pt_left_q <= '0;
            wf_done_o <= 1'b0;
        end else if (cmd[sct_pkg::CMD_WF_STOP]) begin
            wf_q <= 1'b0; // R22
        end else if (wf_start) begin
            wf_q <= 1'b1; // R17
            wf_done_o <= 1'b0;
            up_cnt_q <= up_load_q; // R17
            pt_left_q <= point_n_q;
        end else if (wf_q) begin
            if (up_tick) begin
                up_cnt_q <= (up_cnt_q == '0) ? up_load_q : up_cnt_q - CW'(1);
            end
            if (upd_go) begin
                // update after the last point closes it
                if (pt_left_q == '0) begin
                    wf_q <= 1'b0; // R21 R22
                    wf_done_o <= 1'b1;
                end else begin
                    pt_left_q <= pt_left_q - CW'(1);
                end
            end
        end
    end

    assign status = {27'h0000000, wf_done_o, wf_q, masked, scan_q, acq_q};

    ////////////////////////////////////////////////////////////////////////////////
    // strobes and monitor pins
    logic [sct_pkg::PULSE_W-1:0] scan_pw_q, conv_pw_q, wft_pw_q, upd_pw_q, off_q;
    logic scan_hold_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_convert_o <= 1'b0;
            dac_update_o <= 1'b0;
        end else begin
            adc_convert_o <= conv_go; // R10 R12
            dac_update_o <= upd_go; // R19
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_pw_q <= '0;
            conv_pw_q <= '0;
            wft_pw_q <= '0;
            upd_pw_q <= '0;
        end else begin
            scan_pw_q <= scan_start ? sct_pkg::PULSE_W'(sct_pkg::MON_PULSE_CYC) :
                (scan_pw_q != '0 ? scan_pw_q - 1'b1 : scan_pw_q); // R03
            conv_pw_q <= conv_go ? sct_pkg::PULSE_W'(sct_pkg::MON_PULSE_CYC) :
                (conv_pw_q != '0 ? conv_pw_q - 1'b1 : conv_pw_q); // R11
            wft_pw_q <= wf_start ? sct_pkg::PULSE_W'(sct_pkg::MON_PULSE_CYC) :
                (wft_pw_q != '0 ? wft_pw_q - 1'b1 : wft_pw_q); // R18
            upd_pw_q <= upd_go ? sct_pkg::PULSE_W'(sct_pkg::UPD_PULSE_CYC) :
                (upd_pw_q != '0 ? upd_pw_q - 1'b1 : upd_pw_q); // R20
        end
    end

    // hold option: tail after last conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_hold_q <= 1'b0;
            off_q <= '0;
        end else if (scan_start) begin
            scan_hold_q <= 1'b1; // R04
            off_q <= '0;
        end else if (last_conv || (scan_q && !acq_q)) begin
            off_q <= sct_pkg::PULSE_W'(sct_pkg::SCAN_OFF_CYC); // R04
        end else if (off_q > sct_pkg::PULSE_W'(1)) begin
            off_q <= off_q - 1'b1;
        end else if (off_q == sct_pkg::PULSE_W'(1)) begin
            off_q <= '0;
            scan_hold_q <= 1'b0; // R04
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mon_o <= '{scan: 1'b0, conv_n: 1'b1, wft: 1'b0, upd_n: 1'b1};
            mon_oe_n_o <= 4'hf; // R05
        end else begin
            mon_o.scan <= ctrl_q[sct_pkg::CTRL_SCAN_MON_HOLD] ? (scan_hold_q || scan_start) :
                (scan_start || scan_pw_q > sct_pkg::PULSE_W'(1)); // R03 R04
            mon_o.conv_n <= !(conv_go || conv_pw_q > sct_pkg::PULSE_W'(1)); // R11
            mon_o.wft <= wf_start || wft_pw_q > sct_pkg::PULSE_W'(1); // R18
            mon_o.upd_n <= !(upd_go || upd_pw_q > sct_pkg::PULSE_W'(1)); // R20
            mon_oe_n_o <= ~mon_en_q; // R05
        end
    end

endmodule // sct_timing
`default_nettype wire

// *** src/sct_pkg.sv ***
// package: offsets, fields and timing counts
package sct_pkg;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned CLK_NS = 1000 / CLK_MHZ;
    // widths: shortest legal, rounded up
    localparam int unsigned MON_PULSE_NS = 50;
    localparam int unsigned MON_PULSE_CYC = (MON_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned UPD_PULSE_NS = 300;
    localparam int unsigned UPD_PULSE_CYC = (UPD_PULSE_NS + CLK_NS - 1) / CLK_NS;
    // hold deadline, rounded down
    localparam int unsigned HOLD_NS = 60;
    localparam int unsigned HOLD_CYC = HOLD_NS / CLK_NS;
    // hold-option tail
    localparam int unsigned SCAN_OFF_NS = 40;
    localparam int unsigned SCAN_OFF_CYC = SCAN_OFF_NS / CLK_NS;
    localparam int unsigned PULSE_W = 5;

    localparam int unsigned NUM_PINS = 10;
    localparam int unsigned NUM_FN = 7;
    localparam int unsigned FN_ACQ = 0;
    localparam int unsigned FN_SCAN = 1;
    localparam int unsigned FN_CONV = 2;
    localparam int unsigned FN_MASK = 3;
    localparam int unsigned FN_SICLK = 4;
    localparam int unsigned FN_WFT = 5;
    localparam int unsigned FN_UPD = 6;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ROUTE = 8'h04;
    localparam logic [7:0] OFF_POL = 8'h08;
    localparam logic [7:0] OFF_MON_EN = 8'h0c;
    localparam logic [7:0] OFF_SI_LOAD = 8'h10;
    localparam logic [7:0] OFF_SMP_LOAD = 8'h14;
    localparam logic [7:0] OFF_UP_LOAD = 8'h18;
    localparam logic [7:0] OFF_CONV_N = 8'h1c;
    localparam logic [7:0] OFF_SCAN_N = 8'h20;
    localparam logic [7:0] OFF_POINT_N = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;
    localparam logic [7:0] OFF_CMD = 8'h2c;

    localparam int unsigned CTRL_SCAN_EXT = 0;
    localparam int unsigned CTRL_CONV_EXT = 1;
    localparam int unsigned CTRL_UPD_EXT = 2;
    localparam int unsigned CTRL_SI_EXT = 3;
    localparam int unsigned CTRL_TB_SLOW = 4;
    localparam int unsigned CTRL_SCAN_MON_HOLD = 5;
    localparam int unsigned CTRL_AI_GATE = 6;
    localparam int unsigned CTRL_AO_GATE = 7;
    localparam int unsigned CTRL_DAC_POSTED = 8;
    localparam int unsigned CTRL_MASK_EDGE = 9;
    localparam int unsigned CTRL_ACQ_EXT = 10;
    localparam int unsigned CTRL_WFT_EXT = 11;
    // command fields, write-one pulses
    localparam int unsigned CMD_ACQ_TRIG = 0;
    localparam int unsigned CMD_ACQ_STOP = 1;
    localparam int unsigned CMD_WF_TRIG = 2;
    localparam int unsigned CMD_WF_STOP = 3;
    localparam int unsigned MON_SCAN = 0;
    localparam int unsigned MON_CONV = 1;
    localparam int unsigned MON_WFT = 2;
    localparam int unsigned MON_UPD = 3;
    localparam int unsigned ST_ACQ = 0;
    localparam int unsigned ST_SCAN = 1;
    localparam int unsigned ST_MASKED = 2;
    localparam int unsigned ST_WF = 3;
    localparam int unsigned ST_WF_DONE = 4;
    localparam int unsigned ROUTE_W = 4;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sct_wb_req_t;

    typedef struct packed {
        logic scan;
        logic conv_n;
        logic wft;
        logic upd_n;
    } sct_mon_t;
endpackage : sct_pkg

// *** tb/sct_pin_model.sv ***
// pin-side instruments: levels plus pulse trains
`timescale 1ns/10ps
`default_nettype none
module sct_pin_model #(
    parameter int GAP = 20
) (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [3:0] idx_i,
    input wire logic [7:0] n_i,
    input wire logic [9:0] hold_i,
    output logic [9:0] pins_o,
    output logic busy_o
);
    int cnt_q = 0, left_q = 0;
    logic [3:0] idx_q = 4'h0;
    ////////////////////////////////////////////////////////////////
    // pulses a full gap apart, at least a scan period
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            left_q <= int'(n_i);
            idx_q <= idx_i;
            cnt_q <= 0;
        end else if (left_q != 0) begin
            cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
            if (cnt_q == GAP - 1) left_q <= left_q - 1;
        end
    end
    // 3 cycles away from idle level, above the 2-cycle pin minimum
    always_comb begin
        pins_o = hold_i;
        if (left_q != 0 && cnt_q < 3) pins_o[idx_q] = ~hold_i[idx_q];
    end
    assign busy_o = (left_q != 0);
endmodule // sct_pin_model
`default_nettype wire

// *** tb/sct_timing_sva.sv ***
// assertion checker for the timing engine ports
`timescale 1ns/10ps
`default_nettype none
module sct_timing_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sct_pkg::sct_wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic adc_convert_o,
    input wire logic dac_update_o,
    input wire sct_pkg::sct_mon_t mon_o,
    input wire logic [3:0] mon_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic scan_seen_q, wft_seen_q;
    wire logic wr_req = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we;
    // a strobe is only legal once its start has been shown
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_seen_q <= 1'b0;
            wft_seen_q <= 1'b0;
        end else begin
            scan_seen_q <= scan_seen_q | mon_o.scan;
            wft_seen_q <= wft_seen_q | mon_o.wft;
        end
    end
    sequence s_conv_low;
        (!mon_o.conv_n) [*3] ##1 mon_o.conv_n;
    endsequence
    sequence s_upd_low;
        (!mon_o.upd_n) [*8] ##7 !mon_o.upd_n ##1 mon_o.upd_n;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_conv_width: assert property (adc_convert_o |-> s_conv_low)
        else $error("conversion monitor width wrong");
    a_conv_source: assert property ($fell(mon_o.conv_n) |-> adc_convert_o)
        else $error("conversion monitor without strobe");
    a_upd_width: assert property (dac_update_o |-> s_upd_low)
        else $error("update monitor width wrong");
    a_upd_source: assert property ($fell(mon_o.upd_n) |-> dac_update_o)
        else $error("update monitor without strobe");
    a_scan_width: assert property ($rose(mon_o.scan) |-> mon_o.scan [*3])
        else $error("scan monitor too short");
    a_wft_width: assert property ($rose(mon_o.wft) |-> mon_o.wft [*3] ##1 !mon_o.wft)
        else $error("trigger monitor width wrong");
    a_conv_after_scan: assert property (adc_convert_o |-> scan_seen_q || mon_o.scan)
        else $error("conversion before any scan start");
    a_upd_after_trig: assert property (dac_update_o |-> wft_seen_q || mon_o.wft)
        else $error("update before any waveform trigger");
    a_oe_by_write: assert property ($changed(mon_oe_n_o) |-> $past(wr_req) || $past(wr_req, 2))
        else $error("monitor enable moved without a write");
    a_ack_single: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
endmodule // sct_timing_sva
bind sct_timing sct_timing_sva sct_timing_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_ack_o(wb_ack_o), .adc_convert_o(adc_convert_o), .dac_update_o(dac_update_o), .mon_o(mon_o),
    .mon_oe_n_o(mon_oe_n_o));
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the timing engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, fast_tick = 1'b0, slow_tick = 1'b0, scan_d = 1'b0, go = 1'b0;
    logic wb_ack, conv, upd, wf_done, busy;
    sct_pkg::sct_wb_req_t wb_req = '0;
    sct_pkg::sct_mon_t mon;
    logic [31:0] wb_dat, rd;
    logic [9:0] pins, hold = 10'h3ff;
    logic [3:0] oe_n, pin = 4'h0;
    logic [7:0] npulse = 8'h00;
    int n_fail = 0, n_checks = 0, n_conv = 0, n_upd = 0, n_scan = 0, bc = 0, bs = 0, bu = 0, cyc = 0;
    logic [7:0] ra [6] = '{sct_pkg::OFF_ROUTE, sct_pkg::OFF_POL, sct_pkg::OFF_SI_LOAD,
        sct_pkg::OFF_STATUS, 8'h30, sct_pkg::OFF_CONV_N};
    logic [31:0] rw [6] = '{32'h0765_4321, 32'h0000_007f, 32'hdead_0028, 32'h0000_001f, 32'hffff_ffff, 32'h3};
    logic [31:0] rx [6] = '{32'h0765_4321, 32'h0000_007f, 32'h0000_0028, 32'h0, 32'h0, 32'h3};
    logic [31:0] gate_ctrl [2] = '{32'h0000_0180, 32'h0000_0000};
    sct_timing sct_timing_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack), .pin_i(pins), .tb_fast_tick_i(fast_tick), .tb_slow_tick_i(slow_tick),
        .adc_convert_o(conv), .dac_update_o(upd), .mon_o(mon), .mon_oe_n_o(oe_n), .wf_done_o(wf_done));
    sct_pin_model sct_pin_model_inst (.clk_i(clk_i), .go_i(go), .idx_i(pin), .n_i(npulse),
        .hold_i(hold), .pins_o(pins), .busy_o(busy));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    // ticks, event counts, hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        fast_tick <= (cyc % 5 == 0) || (cyc % 5 == 2);
        slow_tick <= (cyc % 500 == 0);
        scan_d <= mon.scan;
        if (conv === 1'b1) n_conv <= n_conv + 1;
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (mon.scan === 1'b1 && scan_d === 1'b0) n_scan <= n_scan + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int t = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack !== 1'b1 && t < 50);
        rd = wb_dat;
        wb_req <= '0;
        if (t >= 50) check(32'h1, 32'h0);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wait_clear(input int b);
        int t = 0;
        do begin
            wb(1'b0, sct_pkg::OFF_STATUS, 32'h0);
            t++;
        end while (rd[b] !== 1'b0 && t < 400);
        check(rd[b], 32'h0);
        idle(10);
    endtask
    task automatic pulse(input logic [3:0] p, input logic [7:0] n);
        int t = 0;
        go <= 1'b1;
        pin <= p;
        npulse <= n;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            t++;
        end while (busy !== 1'b0 && t < 3000);
        idle(5);
    endtask
    task automatic mark();
        bc = n_conv;
        bs = n_scan;
        bu = n_upd;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        idle(8);
        rst_i <= 1'b0;
        idle(1);
        check(oe_n, 32'hf);
        check(mon, 32'h5);
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, ra[i], rw[i]);
            wb(1'b0, ra[i], 32'h0);
            check(rd, rx[i]);
        end
        $display("register table done");
        // pins idle high, all inverted: active edge falls
        wb(1'b1, sct_pkg::OFF_MON_EN, 32'hf);
        wb(1'b1, sct_pkg::OFF_SMP_LOAD, 32'h4);
        wb(1'b1, sct_pkg::OFF_SCAN_N, 32'h2);
        idle(2);
        check(oe_n, 32'h0);
        mark();
        idle(300);
        check(n_conv - bc, 32'h0);
        wb(1'b1, sct_pkg::OFF_CMD, 32'h1);
        wait_clear(sct_pkg::ST_ACQ);
        check(n_scan - bs, 32'h2);
        check(n_conv - bc, 32'h6);
        $display("internal scan done");
        hold <= 10'h3ef;
        mark();
        wb(1'b1, sct_pkg::OFF_CMD, 32'h1);
        idle(300);
        check(n_scan - bs, 32'h0);
        wb(1'b1, sct_pkg::OFF_CMD, 32'h2);
        hold <= 10'h3ff;
        wb(1'b1, sct_pkg::OFF_CTRL, 32'h200);
        pulse(4'h4, 8'h1);
        wb(1'b1, sct_pkg::OFF_CMD, 32'h1);
        idle(300);
        check(n_scan - bs, 32'h0);
        pulse(4'h4, 8'h1);
        wait_clear(sct_pkg::ST_ACQ);
        check(n_scan - bs, 32'h2);
        $display("scan mask done");
        wb(1'b1, sct_pkg::OFF_CTRL, 32'h3);
        wb(1'b1, sct_pkg::OFF_CONV_N, 32'h2);
        wb(1'b1, sct_pkg::OFF_SCAN_N, 32'h1);
        mark();
        wb(1'b1, sct_pkg::OFF_CMD, 32'h1);
        pulse(4'h3, 8'h1);
        check(n_conv - bc, 32'h0);
        pulse(4'h2, 8'h1);
        pulse(4'h3, 8'h2);
        wait_clear(sct_pkg::ST_ACQ);
        check(n_scan - bs, 32'h1);
        check(n_conv - bc, 32'h2);
        $display("external scan done");
        wb(1'b1, sct_pkg::OFF_CTRL, 32'h100);
        wb(1'b1, sct_pkg::OFF_UP_LOAD, 32'h14);
        wb(1'b1, sct_pkg::OFF_POINT_N, 32'h3);
        mark();
        wb(1'b1, sct_pkg::OFF_CMD, 32'h4);
        wait_clear(sct_pkg::ST_WF);
        check(n_upd - bu, 32'h4);
        check(wf_done, 32'h1);
        foreach (gate_ctrl[i]) begin
            wb(1'b1, sct_pkg::OFF_CTRL, gate_ctrl[i]);
            mark();
            wb(1'b1, sct_pkg::OFF_CMD, 32'h4);
            idle(400);
            check(n_upd - bu, 32'h0);
            wb(1'b1, sct_pkg::OFF_CMD, 32'h8);
        end
        wb(1'b1, sct_pkg::OFF_CTRL, 32'h104);
        mark();
        wb(1'b1, sct_pkg::OFF_CMD, 32'h4);
        pulse(4'h7, 8'h4);
        wait_clear(sct_pkg::ST_WF);
        check(n_upd - bu, 32'h4);
        check(wf_done, 32'h1);
        $display("waveform done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
